// ### rtl/sar_params.svh
// Constants of the conversion control block: widths, codes, field positions, timing.
// Assumes inclusion by bare name from the package, which is compiled ahead of the design file.
`ifndef SAR_PARAMS_SVH
`define SAR_PARAMS_SVH
// Result, configuration and buffer word widths, buffer depth and serial bit counts.
`define RES_BITS 16
`define CFG_BITS 14
`define FIFO_WORD_BITS 31
`define FIFO_DEPTH 8
`define OUT_BITS 30
`define OUT_SHORT 5'h10
`define OUT_LONG 5'h1E
`define IN_FULL 4'hE
`define MSB_INDEX 4'hF
// Code limits and the sign flip between the two codings.
`define CODE_MIN 16'h0000
`define CODE_MAX 16'hFFFF
`define SIGN_FLIP 16'h8000
// Configuration fields used by this block and the reset configuration.
`define CFG_UNIPOLAR_BIT 12
`define CFG_READBACK_BIT 0
`define CFG_RESET 14'h3FFF
// Timing, in nanoseconds and in system clock cycles.
`define CLK_PERIOD_NS 25
`define SWITCH_OPEN_NS 50
`define TRIAL_SETTLE_NS 150
`define SWITCH_OPEN_CLKS 3'((`SWITCH_OPEN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TRIAL_SETTLE_CLKS 3'((`TRIAL_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ### rtl/sar_pkg.sv
// Types shared by the conversion control block.
// Assumes the constant header is on the include path.
`include "sar_params.svh"
package sar_pkg;
  // Conversion sequence states.
  typedef enum logic [2:0] {
    ST_ACQUIRE = 3'b000,
    ST_OPEN = 3'b001,
    ST_TRIAL = 3'b010,
    ST_CODE = 3'b011,
    ST_PUSH = 3'b100
  } conv_state_type;
endpackage : sar_pkg

// ### rtl/sar_conversion_control.sv
// Conversion control for a 16-bit successive-approximation converter with a serial port.
// Assumes clk_in is the internal conversion clock, the serial clock is a separate domain
// that runs in host frames and in bursts with the start pin high, and the comparator is asynchronous.
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////////////////
// Result buffer between the converter and the serial port.
//////////////////////////////////////////////////////////////////////////////////////////
module result_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_in,
  // Fill side.
  input wire logic [WIDTH-1:0] fill_data_in,
  input wire logic fill_valid_in,
  output logic fill_ready_out,
  // Drain side.
  output logic [WIDTH-1:0] drain_data_out,
  output logic drain_valid_out,
  input wire logic drain_ready_in
);
  localparam int AW = $clog2(DEPTH);
  // All storage and pointers in one record.
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
  } fifo_state_type;
  fifo_state_type st_r;
  fifo_state_type st_nxt;
  logic do_push;
  logic do_pop;

  // Full and empty come from the count, so both are exact.
  always_comb begin
    do_push = fill_valid_in && (st_r.count != (AW+1)'(DEPTH));
    do_pop = drain_ready_in && (st_r.count != '0);
    st_nxt = st_r;
    if (do_push) begin
      st_nxt.mem[st_r.wr_ptr] = fill_data_in;
      st_nxt.wr_ptr = AW'(st_r.wr_ptr + 1'b1);
    end
    if (do_pop) begin
      st_nxt.rd_ptr = AW'(st_r.rd_ptr + 1'b1);
    end
    // Simultaneous push and pop leave the count as it was.
    if (do_push && !do_pop) begin
      st_nxt.count = (AW+1)'(st_r.count + 1'b1);
    end else if (do_pop && !do_push) begin
      st_nxt.count = (AW+1)'(st_r.count - 1'b1);
    end
  end

  // State register; reset clears the contents as well as the pointers and the count.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign fill_ready_out = (st_r.count != (AW+1)'(DEPTH));
  assign drain_valid_out = (st_r.count != '0);
  assign drain_data_out = st_r.mem[st_r.rd_ptr];
endmodule : result_fifo

//////////////////////////////////////////////////////////////////////////////////////////
// Top module.
//////////////////////////////////////////////////////////////////////////////////////////
module sar_conversion_control
  import sar_pkg::*;
(
  // System clock and reset.
  input wire logic clk_in,
  input wire logic rst_in,
  // Conversion start and analog front end.
  input wire logic conversion_start_input_in,
  input wire logic comparator_in,
  output logic positive_sample_switch_out,
  output logic negative_sample_switch_out,
  output logic [`RES_BITS-1:0] dac_trial_out,
  output logic converter_power_out,
  output logic busy_out,
  // Serial port, clocked by the host.
  input wire logic serial_clock_in,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_oe_out
);
  // System domain state.
  typedef struct packed {
    logic [2:0] cnv_sync;
    logic cnv_lvl;
    logic [2:0] cmp_sync;
    logic cmp_lvl;
    conv_state_type state;
    logic [3:0] bit_idx;
    logic [2:0] wait_cnt;
    logic [`RES_BITS-1:0] trial;
    logic [`CFG_BITS-1:0] cfg;
    logic [`CFG_BITS-1:0] cfg_snap;
    logic [`FIFO_WORD_BITS-1:0] push_word;
    logic push_valid;
    logic busy;
    logic sw_closed;
    logic power;
    logic [`FIFO_WORD_BITS-1:0] tx_word;
    logic tx_pending;
    logic tx_tog;
    logic [2:0] ack_sync;
    logic ack_seen;
    logic [2:0] rx_sync;
    logic rx_seen;
  } sys_state_type;

  // Link domain state.
  typedef struct packed {
    logic [2:0] rst_sync;
    logic [2:0] cnv_sync;
    logic frame;
    logic [2:0] tx_sync;
    logic tx_seen;
    logic ack_tog;
    logic [`OUT_BITS-1:0] out_shift;
    logic [4:0] out_cnt;
    logic [`CFG_BITS-1:0] in_shift;
    logic [3:0] in_cnt;
    logic [`CFG_BITS-1:0] rx_word;
    logic rx_tog;
    logic [2:0] busy_sync;
    logic sdo;
    logic sdo_oe;
  } link_state_type;

  sys_state_type s_r;
  sys_state_type s_nxt;
  link_state_type l_r;
  link_state_type l_nxt;
  logic fifo_ready; // Back-pressure from the buffer into the sequencer.
  logic [`FIFO_WORD_BITS-1:0] fifo_word;
  logic fifo_valid;
  logic fifo_take; // Drain request from the hand-over stage.
  logic link_rst; // Reset as seen by the link domain.

  ////////////////////////////////////////////////////////////////////////////////////////
  // System domain: conversion sequence, coding, buffering and hand-over.
  ////////////////////////////////////////////////////////////////////////////////////////

  // The drain side only pulls a word when the previous one has been collected.
  assign fifo_take = fifo_valid && !s_r.tx_pending;

  // Next-state logic of the conversion sequence.
  always_comb begin
    s_nxt = s_r;
    s_nxt.push_valid = 1'b0;
    // Three-stage capture of the asynchronous start and comparator levels.
    s_nxt.cnv_sync = {s_r.cnv_sync[1:0], conversion_start_input_in};
    s_nxt.cmp_sync = {s_r.cmp_sync[1:0], comparator_in};
    if (s_r.cnv_sync[1] == s_r.cnv_sync[2]) begin
      s_nxt.cnv_lvl = s_r.cnv_sync[2];
    end
    if (s_r.cmp_sync[1] == s_r.cmp_sync[2]) begin
      s_nxt.cmp_lvl = s_r.cmp_sync[2];
    end
    // New configuration words arrive by toggle; the word is stable once the toggle is seen.
    s_nxt.rx_sync = {s_r.rx_sync[1:0], l_r.rx_tog};
    if ((s_r.rx_sync[1] == s_r.rx_sync[2]) && (s_r.rx_sync[2] != s_r.rx_seen)) begin
      s_nxt.rx_seen = s_r.rx_sync[2];
      s_nxt.cfg = l_r.rx_word;
    end
    // Collected words are acknowledged by toggle from the link side.
    s_nxt.ack_sync = {s_r.ack_sync[1:0], l_r.ack_tog};
    if ((s_r.ack_sync[1] == s_r.ack_sync[2]) && (s_r.ack_sync[2] != s_r.ack_seen)) begin
      s_nxt.ack_seen = s_r.ack_sync[2];
      s_nxt.tx_pending = 1'b0;
    end
    // Offer the oldest buffered result to the link side.
    if (fifo_take) begin
      s_nxt.tx_word = fifo_word;
      s_nxt.tx_pending = 1'b1;
      s_nxt.tx_tog = ~s_r.tx_tog;
    end
    case (s_r.state)
      // Switches closed, converter powered down, waiting for a start edge.
      ST_ACQUIRE: begin
        s_nxt.sw_closed = 1'b1;
        s_nxt.power = 1'b0;
        s_nxt.busy = 1'b0;
        if (s_nxt.cnv_lvl && !s_r.cnv_lvl) begin
          s_nxt.state = ST_OPEN;
          s_nxt.sw_closed = 1'b0;
          s_nxt.power = 1'b1;
          s_nxt.busy = 1'b1;
          s_nxt.cfg_snap = s_r.cfg;
          s_nxt.trial = `CODE_MIN;
          s_nxt.wait_cnt = `SWITCH_OPEN_CLKS;
        end
      end
      // Let the switches open fully before the first trial.
      ST_OPEN: begin
        if (s_r.wait_cnt != 3'h0) begin
          s_nxt.wait_cnt = 3'(s_r.wait_cnt - 1'b1);
        end else begin
          s_nxt.state = ST_TRIAL;
          s_nxt.bit_idx = `MSB_INDEX;
          s_nxt.trial[`MSB_INDEX] = 1'b1;
          s_nxt.wait_cnt = `TRIAL_SETTLE_CLKS;
        end
      end
      // One bit per step; the settle time covers the comparator's capture stages.
      ST_TRIAL: begin
        if (s_r.wait_cnt != 3'h0) begin
          s_nxt.wait_cnt = 3'(s_r.wait_cnt - 1'b1);
        end else begin
          // A low comparator means the trial overshot the input; drop the bit.
          s_nxt.trial[s_r.bit_idx] = s_r.cmp_lvl;
          if (s_r.bit_idx == 4'h0) begin
            s_nxt.state = ST_CODE;
          end else begin
            s_nxt.bit_idx = 4'(s_r.bit_idx - 1'b1);
            s_nxt.trial[4'(s_r.bit_idx - 1'b1)] = 1'b1;
            s_nxt.wait_cnt = `TRIAL_SETTLE_CLKS;
          end
        end
      end
      // Form the output code. A comparator stuck high gives all ones and stuck low all
      // zeros, so over- and under-range saturate without extra logic.
      ST_CODE: begin
        s_nxt.sw_closed = 1'b1;
        s_nxt.power = 1'b0;
        s_nxt.push_word[`FIFO_WORD_BITS-1] = s_r.cfg_snap[`CFG_READBACK_BIT];
        s_nxt.push_word[`FIFO_WORD_BITS-2 -: `CFG_BITS] = s_r.cfg_snap;
        if (s_r.cfg_snap[`CFG_UNIPOLAR_BIT]) begin
          s_nxt.push_word[`RES_BITS-1:0] = s_r.trial;
        end else begin
          s_nxt.push_word[`RES_BITS-1:0] = s_r.trial ^ `SIGN_FLIP;
        end
        s_nxt.push_valid = 1'b1;
        s_nxt.state = ST_PUSH;
      end
      // Hold the word until the buffer takes it; a full buffer stalls the next start.
      ST_PUSH: begin
        s_nxt.push_valid = 1'b1;
        if (s_r.push_valid && fifo_ready) begin
          s_nxt.push_valid = 1'b0;
          s_nxt.busy = 1'b0;
          s_nxt.state = ST_ACQUIRE;
        end
      end
      default: begin
        s_nxt.state = ST_ACQUIRE;
      end
    endcase
  end

  // System state register; all timing runs on the internal clock.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_r <= '0;
      s_r.cfg <= `CFG_RESET;
      s_r.cfg_snap <= `CFG_RESET;
      s_r.sw_closed <= 1'b1;
      s_r.state <= ST_ACQUIRE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Results wait here so a slow reader does not lose samples.
  result_fifo #(
    .WIDTH(`FIFO_WORD_BITS),
    .DEPTH(`FIFO_DEPTH)
  ) u_result_fifo (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .fill_data_in(s_r.push_word),
    .fill_valid_in(s_r.push_valid),
    .fill_ready_out(fifo_ready),
    .drain_data_out(fifo_word),
    .drain_valid_out(fifo_valid),
    .drain_ready_in(fifo_take)
  );

  ////////////////////////////////////////////////////////////////////////////////////////
  // Link domain: serial shifting on the host's clock.
  ////////////////////////////////////////////////////////////////////////////////////////

  // Reset counts once its second and third capture stages agree high.
  assign link_rst = l_r.rst_sync[1] && l_r.rst_sync[2];

  // Next-state logic of the serial port.
  always_comb begin
    l_nxt = l_r;
    l_nxt.rst_sync = {l_r.rst_sync[1:0], rst_in};
    l_nxt.cnv_sync = {l_r.cnv_sync[1:0], conversion_start_input_in};
    l_nxt.tx_sync = {l_r.tx_sync[1:0], s_r.tx_tog};
    l_nxt.busy_sync = {l_r.busy_sync[1:0], s_r.busy};
    // A frame is open while the start input is low.
    if (l_r.cnv_sync[1] == l_r.cnv_sync[2]) begin
      l_nxt.frame = ~l_r.cnv_sync[2];
    end
    l_nxt.sdo_oe = l_nxt.frame;
    if (l_nxt.frame && !l_r.frame) begin
      // Frame opens: restart the input count and load a waiting result.
      l_nxt.in_cnt = 4'h0;
      l_nxt.out_cnt = 5'h0;
      l_nxt.sdo = 1'b0;
      if ((l_r.tx_sync[1] == l_r.tx_sync[2]) && (l_r.tx_sync[2] != l_r.tx_seen)) begin
        l_nxt.tx_seen = l_r.tx_sync[2];
        l_nxt.ack_tog = ~l_r.ack_tog;
        // The result goes first and the applied configuration follows it.
        l_nxt.out_shift = {s_r.tx_word[`RES_BITS-1:0],
                           s_r.tx_word[`FIFO_WORD_BITS-2 -: `CFG_BITS]};
        if (s_r.tx_word[`FIFO_WORD_BITS-1]) begin
          l_nxt.out_cnt = `OUT_LONG;
        end else begin
          l_nxt.out_cnt = `OUT_SHORT;
          l_nxt.out_shift = {s_r.tx_word[`RES_BITS-1:0], `CFG_BITS'(0)};
        end
      end
    end else if (l_r.frame) begin
      // Configuration bits enter most significant first; extras are ignored.
      if (l_r.in_cnt != `IN_FULL) begin
        l_nxt.in_shift = {l_r.in_shift[`CFG_BITS-2:0], serial_data_in};
        l_nxt.in_cnt = 4'(l_r.in_cnt + 1'b1);
        if (l_r.in_cnt == 4'(`IN_FULL - 1'b1)) begin
          l_nxt.rx_word = {l_r.in_shift[`CFG_BITS-2:0], serial_data_in};
          l_nxt.rx_tog = ~l_r.rx_tog;
        end
      end
      if (l_r.out_cnt != 5'h0) begin
        l_nxt.sdo = l_r.out_shift[`OUT_BITS-1];
        l_nxt.out_shift = {l_r.out_shift[`OUT_BITS-2:0], 1'b0};
        l_nxt.out_cnt = 5'(l_r.out_cnt - 1'b1);
      end else if (l_r.busy_sync[1] == l_r.busy_sync[2]) begin
        // Low while converting, high once done.
        l_nxt.sdo = ~l_r.busy_sync[2];
      end
    end
  end

  // Link state register; the reset capture stages themselves are never cleared.
  always_ff @(posedge serial_clock_in) begin
    if (link_rst) begin
      l_r <= '0;
      l_r.rst_sync <= l_nxt.rst_sync;
    end else begin
      l_r <= l_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  // Outputs, each straight from a flip-flop.
  ////////////////////////////////////////////////////////////////////////////////////////
  assign positive_sample_switch_out = s_r.sw_closed;
  assign negative_sample_switch_out = s_r.sw_closed;
  assign dac_trial_out = s_r.trial;
  assign converter_power_out = s_r.power;
  assign busy_out = s_r.busy;
  assign serial_data_out = l_r.sdo;
  assign serial_data_oe_out = l_r.sdo_oe;
endmodule : sar_conversion_control

// ### sim/sar_conv_checker_sva.sv
// Concurrent checks on the conversion control ports.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module sar_conv_checker (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_in,
  // Converter side.
  input wire logic conversion_start_input_in,
  input wire logic positive_sample_switch_out,
  input wire logic negative_sample_switch_out,
  input wire logic [15:0] dac_trial_out,
  input wire logic converter_power_out,
  input wire logic busy_out,
  // Serial side.
  input wire logic serial_data_oe_out
);
  // Cycles spent powered in the current conversion; a restart would stretch it.
  logic [7:0] on_cnt_r;

  //////////////////////////////////////////////////////////////////////////////
  // Helper counter, cleared whenever the converter is powered down.
  always_ff @(posedge clk_in) begin
    if (rst_in || !converter_power_out) on_cnt_r <= 8'h00;
    else on_cnt_r <= on_cnt_r + 8'h01;
  end

  //////////////////////////////////////////////////////////////////////////////
  // All checks share the system clock and its reset.
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  start_opens_a: assert property ($rose(busy_out) |-> !positive_sample_switch_out
    && converter_power_out) else $error("switches not opened at start");
  switch_pair_a: assert property (positive_sample_switch_out == negative_sample_switch_out)
    else $error("sample switches disagree");
  first_trial_a: assert property ($rose(converter_power_out) |-> ##[1:8]
    (dac_trial_out == 16'h8000)) else $error("first trial is not the top bit");
  msb_first_a: assert property (converter_power_out && $past(converter_power_out)
    && $changed(dac_trial_out) && !$past(dac_trial_out[0]) && $past(dac_trial_out) != 16'h0000
    |-> (dac_trial_out & (~dac_trial_out + 16'h0001)) <
        ($past(dac_trial_out) & (~$past(dac_trial_out) + 16'h0001)))
    else $error("trial order not top bit first");
  conv_length_a: assert property ($fell(converter_power_out) |->
    on_cnt_r inside {[8'h64:8'h82]}) else $error("conversion length out of range");
  back_to_acq_a: assert property ($fell(converter_power_out) |-> positive_sample_switch_out)
    else $error("no return to acquisition");
  busy_end_a: assert property ($fell(busy_out) |-> !converter_power_out)
    else $error("busy ended while converting");
  idle_acq_a: assert property (!busy_out |-> positive_sample_switch_out
    && !converter_power_out) else $error("idle but not acquiring");
  no_restart_a: assert property ($past(busy_out) |-> !$rose(converter_power_out))
    else $error("conversion restarted while busy");

  // Main scenarios: a finished conversion, a result waiting for the buffer, an open frame.
  done_c: cover property ($fell(busy_out));
  stall_c: cover property (busy_out && !converter_power_out);
  frame_c: cover property (serial_data_oe_out && !conversion_start_input_in);
endmodule : sar_conv_checker

bind sar_conversion_control sar_conv_checker i_chk (.clk_in(clk_in), .rst_in(rst_in),
  .conversion_start_input_in(conversion_start_input_in),
  .positive_sample_switch_out(positive_sample_switch_out),
  .negative_sample_switch_out(negative_sample_switch_out), .dac_trial_out(dac_trial_out),
  .converter_power_out(converter_power_out), .busy_out(busy_out),
  .serial_data_oe_out(serial_data_oe_out));

// ### sim/host_model.sv
// Host controller model: start pin and a 160 ns serial clock that runs in frames, in reset bursts, and in trailing bursts with the pin high.
// Assumes the bench calls its tasks; the start pin moves on falling system edges.
`timescale 1ns/1ps
module host_model (
  // System clock, used only to time the start pin.
  input wire logic clk_in,
  // Serial data from the converter.
  input wire logic dev_data_in,
  // Pins driven by the host.
  output logic start_out,
  output logic sclk_out,
  output logic host_data_out
);
  initial begin
    start_out = 1'b0;
    sclk_out = 1'b0;
    host_data_out = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // A few serial edges so the link side leaves reset.
  task link_reset();
    repeat (6) begin
      #80 sclk_out = 1'b1;
      #80 sclk_out = 1'b0;
    end
  endtask : link_reset

  // Rising start edge; the host only does this after acquisition has run.
  task raise();
    @(negedge clk_in) start_out = 1'b1;
  endtask : raise

  // Short low pulse on the start pin without any serial clock.
  task pulse();
    @(negedge clk_in) start_out = 1'b0;
    repeat (6) @(negedge clk_in);
    raise();
  endtask : pulse

  // One frame: four lead-in edges, the data bits, one trailing bit, then a new start.
  task frame(input int nbits, input logic [13:0] cfg, output logic [30:0] word);
    int k;
    word = '0;
    @(negedge clk_in) start_out = 1'b0;
    for (k = 1; k <= nbits + 5; k++) begin
      // Unused data slots toggle so a stale level never reads as a bit.
      #40 host_data_out = (k >= 5 && k < 19) ? cfg[18 - k] : ~host_data_out;
      #40 sclk_out = 1'b1;
      #80 if (k >= 5) word = {word[29:0], dev_data_in};
      sclk_out = 1'b0;
    end
    raise();
    // Trailing edges let the link side see the pin high again.
    repeat (4) begin
      #80 sclk_out = 1'b1;
      #80 sclk_out = 1'b0;
    end
  endtask : frame
endmodule : host_model

// ### sim/sar_conversion_control_test.sv
// Self-checking bench for the conversion control block.
// Assumes the host model and the bound checker are compiled with it.
`timescale 1ns/1ps
module sar_conversion_control_test;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic comparator_in = 1'b0;
  logic [15:0] analog_level = 16'h8000; // Input level, as a straight binary code.
  logic start, sclk, sdi, sw_pos, sw_neg, power, busy, sdo, sdo_oe;
  logic [15:0] trial;
  logic [30:0] w;
  int failures = 0;
  int checked = 0;
  // Levels, written configurations and expected codes of the previous conversion.
  localparam logic [15:0] LVL [5] = '{16'h8000, 16'hFFFF, 16'h0000, 16'hFFFF, 16'h0000};
  localparam logic [13:0] CFG [5] = '{14'h2FFE, 14'h2FFE, 14'h2FFE, 14'h3FFE, 14'h3FFE};
  localparam logic [15:0] EXP [5] = '{16'hFFFF, 16'h0000, 16'h7FFF, 16'h8000, 16'hFFFF};

  sar_conversion_control i_dut (.clk_in(clk_in), .rst_in(rst_in),
    .conversion_start_input_in(start), .comparator_in(comparator_in),
    .positive_sample_switch_out(sw_pos), .negative_sample_switch_out(sw_neg),
    .dac_trial_out(trial), .converter_power_out(power), .busy_out(busy),
    .serial_clock_in(sclk), .serial_data_in(sdi), .serial_data_out(sdo),
    .serial_data_oe_out(sdo_oe));
  host_model i_host (.clk_in(clk_in), .dev_data_in(sdo), .start_out(start),
    .sclk_out(sclk), .host_data_out(sdi));

  //////////////////////////////////////////////////////////////////////////////
  // 40 MHz system clock.
  initial forever #12.5 clk_in = ~clk_in;

  // Comparator: high while the input is at or above the trial level.
  always @(negedge clk_in) comparator_in <= (analog_level >= trial);

  //////////////////////////////////////////////////////////////////////////////
  task check(input string name, input logic [30:0] exp, input logic [30:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task final_report();
    if (failures == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report

  // Waits, bounded, for the conversion just started to hand over its result.
  task wait_idle();
    int n;
    n = 0;
    repeat (8) @(negedge clk_in);
    while (busy !== 1'b0 && n < 2000) begin
      @(negedge clk_in);
      n++;
    end
    check("busy released", 31'(0), 31'(busy));
  endtask : wait_idle

  //////////////////////////////////////////////////////////////////////////////
  // A second start edge in mid-conversion must not restart or add a conversion.
  task t_restart();
    logic seen;
    seen = 1'b0;
    repeat (4) @(negedge clk_in);
    i_host.raise();
    // Serial edges with the pin high release the link side and leave its frame closed.
    i_host.link_reset();
    check("enable outside frame", 31'(0), 31'(sdo_oe));
    i_host.pulse();
    wait_idle();
    repeat (60) begin
      @(negedge clk_in);
      seen = seen | busy;
    end
    check("busy after ignored edge", 31'(0), 31'(seen));
  endtask : t_restart

  // Reset configuration appends itself; the frame writes a bipolar setting.
  task t_readback();
    logic oe_mid;
    analog_level = 16'h7FFF;
    oe_mid = 1'b0;
    // The output enable is sampled well inside the frame, after it has opened.
    fork
      i_host.frame(30, 14'h2FFE, w);
      begin
        #2000;
        oe_mid = sdo_oe;
      end
    join
    check("word with config", {16'h8000, 14'h3FFF, 1'b1}, w);
    check("enable in frame", 31'(1), 31'(oe_mid));
    check("enable after frame", 31'(0), 31'(sdo_oe));
    wait_idle();
  endtask : t_readback

  // Both codings, midscale and saturation, one frame per previous result.
  task t_codes();
    for (int i = 0; i < 5; i++) begin
      analog_level = LVL[i];
      i_host.frame(16, CFG[i], w);
      check("code and busy bit", {14'h0000, EXP[i], 1'b1}, w);
      wait_idle();
    end
  endtask : t_codes

  // With the hand-over stage already holding a result, fill the eight-word buffer; the ninth result stalls busy.
  task t_fifo();
    for (int i = 1; i <= 9; i++) begin
      analog_level = 16'(i * 16'h1111);
      i_host.pulse();
      if (i < 9) wait_idle();
    end
    repeat (300) @(negedge clk_in);
    check("busy while buffer full", 31'(1), 31'(busy));
    for (int i = 0; i <= 9; i++) begin
      i_host.frame(16, 14'h3FFE, w);
      check("drained code", 31'(i * 16'h1111), 31'(w[16:1]));
    end
  endtask : t_fifo

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence; the link side needs serial edges while reset is high.
  initial begin
    i_host.link_reset();
    repeat (12) @(negedge clk_in);
    rst_in = 1'b0;
    t_restart();
    t_readback();
    t_codes();
    t_fifo();
    final_report();
  end

  // Watchdog well beyond the expected run of about 120 us.
  initial begin
    #1_000_000;
    failures++;
    final_report();
  end
endmodule : sar_conversion_control_test
